// ==== rtl/int_event_pkg.sv ====
package int_event_pkg;
    // Sizes of the node set
    localparam int NUM_SRC = 27;
    localparam int NUM_EXT = 8;
    localparam int NUM_CHAN = 8;
    localparam int IDX_W = 5;
    localparam int LVL_W = 4;
    localparam int CH_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register map (index = address)
    localparam logic [7:0] SRC_BASE = 8'h00;
    localparam logic [7:0] CH_CTRL_BASE = 8'h20;
    localparam logic [7:0] CH_SRC_BASE = 8'h28;
    localparam logic [7:0] CH_DST_BASE = 8'h30;
    localparam logic [7:0] EDGE_CFG_ADDR = 8'h38;
    localparam logic [7:0] STATUS_ADDR = 8'h39;

    // Source control field positions
    localparam int F_LVL = 0;
    localparam int F_CHAN = 4;
    localparam int F_USECH = 7;
    localparam int F_IE = 8;
    localparam int F_IR = 9;
    // Channel control field positions
    localparam int F_COUNT = 0;
    localparam int F_BYTE = 8;
    localparam int F_INCDST = 9;
    localparam int F_CONT = 10;

    // Edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;
    localparam logic [15:0] PTR_STEP_WORD = 16'h0002;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
    localparam logic [1:0] VEC_SHIFT_PAD = 2'h0;

    // Trap number of each node; vector address is trap number times four
    localparam logic [7:0] TRAP_NUM [NUM_SRC] = '{
        8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F,
        8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
        8'h2A, 8'h47, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h40,
        8'h41, 8'h42, 8'h43};

    typedef enum logic [1:0] {ST_IDLE, ST_IRQ, ST_XFER} svc_state_t;

    typedef struct packed {
        logic ir;
        logic ie;
        logic use_chan;
        logic [CH_W-1:0] chan;
        logic [LVL_W-1:0] lvl;
    } src_ctrl_t;

    typedef struct packed {
        logic cont;
        logic inc_dst;
        logic byte_mode;
        logic [7:0] count;
        logic [15:0] src_ptr;
        logic [15:0] dst_ptr;
    } chan_t;

    typedef struct packed {
        logic [15:0] src_addr;
        logic [15:0] dst_addr;
        logic byte_mode;
    } xfer_t;

    typedef struct packed {
        logic [9:0] vector;
        logic [LVL_W-1:0] lvl;
        logic trap;
    } irq_t;
endpackage

// ==== rtl/edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module edge_detect
    import int_event_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_EXT-1:0] pin,
    input wire logic [2*NUM_EXT-1:0] cfg,
    output logic [NUM_EXT-1:0] pulse
);
    logic [NUM_EXT-1:0] prev_q;

    // One detector per fast input; pins are already in the clock domain
    for (genvar i = 0; i < NUM_EXT; i++) begin : g_edge
        logic rise;
        logic fall;
        assign rise = pin[i] & ~prev_q[i];
        assign fall = ~pin[i] & prev_q[i];
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                prev_q[i] <= 1'b0;
                pulse[i] <= 1'b0;
            end else begin
                prev_q[i] <= pin[i];
                unique case (cfg[2*i +: 2])
                    EDGE_OFF: pulse[i] <= 1'b0;
                    EDGE_RISE: pulse[i] <= rise;
                    EDGE_FALL: pulse[i] <= fall;
                    EDGE_BOTH: pulse[i] <= rise | fall;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/prio_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter
    import int_event_pkg::*;
(
    input wire logic [NUM_SRC-1:0] req,
    input wire logic [NUM_SRC-1:0][LVL_W-1:0] lvl,
    output logic win_valid,
    output logic [IDX_W-1:0] win_idx,
    output logic [LVL_W-1:0] win_lvl
);
    // Scan from the top so the lowest node index wins a tie
    always_comb begin
        win_valid = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && (!win_valid || lvl[i] >= win_lvl)) begin
                win_valid = 1'b1;
                win_idx = IDX_W'(i);
                win_lvl = lvl[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/int_event_unit.sv ====
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module int_event_unit
    import int_event_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [NUM_EXT-1:0] ext_pin,
    input wire logic [NUM_SRC-1:0] src_evt,
    input wire logic [LVL_W-1:0] cpu_level,
    input wire logic hw_trap_active,
    input wire logic trap_req,
    input wire logic [7:0] trap_num,
    input wire logic cpu_ack,
    output logic irq_req,
    output irq_t irq_info,
    output logic xfer_go,
    output xfer_t xfer_info
);
    src_ctrl_t [NUM_SRC-1:0] src_q;
    chan_t [NUM_CHAN-1:0] chan_q;
    logic [2*NUM_EXT-1:0] edge_cfg_q;
    svc_state_t state_q;
    logic [IDX_W-1:0] svc_idx_q;
    logic [CH_W-1:0] svc_chan_q;
    logic trap_pend_q;
    logic [7:0] trap_num_q;

    logic [NUM_EXT-1:0] ext_pulse;
    logic [NUM_SRC-1:0] hw_set;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0][LVL_W-1:0] lvls;
    logic win_valid;
    logic [IDX_W-1:0] win_idx;
    logic [LVL_W-1:0] win_lvl;
    src_ctrl_t win_src;
    chan_t win_chan;
    logic win_to_chan;
    logic take_irq;
    logic take_xfer;
    logic clear_svc;

    edge_detect u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .pin(ext_pin),
        .cfg(edge_cfg_q),
        .pulse(ext_pulse)
    );

    // Fast external inputs feed the first eight nodes
    assign hw_set = src_evt | {{(NUM_SRC - NUM_EXT){1'b0}}, ext_pulse};

    // Enabled pending requests and their levels
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_pend
        assign pend[i] = src_q[i].ir & src_q[i].ie;
        assign lvls[i] = src_q[i].lvl;
    end

    prio_arbiter u_arb (
        .req(pend),
        .lvl(lvls),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    );

    // Routing of the winner; an exhausted channel falls back to its vector
    assign win_src = src_q[win_idx];
    assign win_chan = chan_q[win_src.chan];
    assign win_to_chan = win_src.use_chan
        & (win_chan.cont | (win_chan.count != '0));
    // Hardware traps hold off every request; level must beat the CPU's own
    assign take_irq = (state_q == ST_IDLE) & !hw_trap_active & !trap_pend_q
        & win_valid & (win_lvl > cpu_level) & !win_to_chan;
    assign take_xfer = (state_q == ST_IDLE) & !hw_trap_active & !trap_pend_q
        & win_valid & (win_lvl > cpu_level) & win_to_chan;
    // Flag clears when the CPU takes the vector or the transfer is done
    assign clear_svc = ((state_q == ST_IRQ) & cpu_ack & !irq_info.trap)
        | (state_q == ST_XFER);

    // Source control registers; a hardware event beats any clear
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        logic wr_hit;
        logic svc_hit;
        assign wr_hit = wr & (addr == SRC_BASE + 8'(i));
        assign svc_hit = clear_svc & (svc_idx_q == IDX_W'(i));
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                src_q[i] <= '0;
            end else begin
                if (wr_hit) begin
                    src_q[i].lvl <= wdata[F_LVL +: LVL_W];
                    src_q[i].chan <= wdata[F_CHAN +: CH_W];
                    src_q[i].use_chan <= wdata[F_USECH];
                    src_q[i].ie <= wdata[F_IE];
                end
                if (hw_set[i]) begin
                    src_q[i].ir <= 1'b1;
                end else if (wr_hit) begin
                    src_q[i].ir <= wdata[F_IR];
                end else if (svc_hit) begin
                    src_q[i].ir <= 1'b0;
                end
            end
        end
    end

    // Channel registers; software writes and the engine's own update
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        logic svc_hit;
        logic [15:0] step;
        assign svc_hit = (state_q == ST_XFER) & (svc_chan_q == CH_W'(c));
        assign step = chan_q[c].byte_mode ? PTR_STEP_BYTE : PTR_STEP_WORD;
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                chan_q[c] <= '0;
            end else if (wr && addr == CH_CTRL_BASE + 8'(c)) begin
                chan_q[c].count <= wdata[F_COUNT +: 8];
                chan_q[c].byte_mode <= wdata[F_BYTE];
                chan_q[c].inc_dst <= wdata[F_INCDST];
                chan_q[c].cont <= wdata[F_CONT];
            end else if (wr && addr == CH_SRC_BASE + 8'(c)) begin
                chan_q[c].src_ptr <= wdata;
            end else if (wr && addr == CH_DST_BASE + 8'(c)) begin
                chan_q[c].dst_ptr <= wdata;
            end else if (svc_hit) begin
                if (chan_q[c].inc_dst) begin
                    chan_q[c].dst_ptr <= chan_q[c].dst_ptr + step;
                end else begin
                    chan_q[c].src_ptr <= chan_q[c].src_ptr + step;
                end
                if (!chan_q[c].cont) begin
                    chan_q[c].count <= chan_q[c].count - COUNT_ONE;
                end
            end
        end
    end

    // Edge selection register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_cfg_q <= '0;
        end else if (wr && addr == EDGE_CFG_ADDR) begin
            edge_cfg_q <= wdata;
        end
    end

    // Trap instruction is latched until the controller is free
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_pend_q <= 1'b0;
            trap_num_q <= '0;
        end else if (trap_req) begin
            trap_pend_q <= 1'b1;
            trap_num_q <= trap_num;
        end else if (state_q == ST_IDLE && !hw_trap_active) begin
            trap_pend_q <= 1'b0;
        end
    end

    // Service sequencer: one decision cycle keeps response inside budget
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            svc_idx_q <= '0;
            svc_chan_q <= '0;
            irq_req <= 1'b0;
            irq_info <= '0;
            xfer_go <= 1'b0;
            xfer_info <= '0;
        end else begin
            xfer_go <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (trap_pend_q && !hw_trap_active) begin
                        irq_req <= 1'b1;
                        irq_info.vector <= {trap_num_q, VEC_SHIFT_PAD};
                        irq_info.lvl <= cpu_level;
                        irq_info.trap <= 1'b1;
                        state_q <= ST_IRQ;
                    end else if (take_irq) begin
                        irq_req <= 1'b1;
                        irq_info.vector <= {TRAP_NUM[win_idx], VEC_SHIFT_PAD};
                        irq_info.lvl <= win_lvl;
                        irq_info.trap <= 1'b0;
                        svc_idx_q <= win_idx;
                        state_q <= ST_IRQ;
                    end else if (take_xfer) begin
                        xfer_go <= 1'b1;
                        xfer_info.src_addr <= win_chan.src_ptr;
                        xfer_info.dst_addr <= win_chan.dst_ptr;
                        xfer_info.byte_mode <= win_chan.byte_mode;
                        svc_idx_q <= win_idx;
                        svc_chan_q <= win_src.chan;
                        state_q <= ST_XFER;
                    end
                end
                ST_IRQ: begin
                    if (cpu_ack) begin
                        irq_req <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_XFER: begin
                    // Pointer and count update happen in this cycle
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Read port: data stand in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= RESET_WORD;
        end else if (rd) begin
            rdata <= RESET_WORD;
            if (addr < SRC_BASE + 8'(NUM_SRC)) begin
                rdata[F_LVL +: LVL_W] <= src_q[addr[IDX_W-1:0]].lvl;
                rdata[F_CHAN +: CH_W] <= src_q[addr[IDX_W-1:0]].chan;
                rdata[F_USECH] <= src_q[addr[IDX_W-1:0]].use_chan;
                rdata[F_IE] <= src_q[addr[IDX_W-1:0]].ie;
                rdata[F_IR] <= src_q[addr[IDX_W-1:0]].ir;
            end else if (addr >= CH_CTRL_BASE && addr < CH_SRC_BASE) begin
                rdata[F_COUNT +: 8] <= chan_q[addr[CH_W-1:0]].count;
                rdata[F_BYTE] <= chan_q[addr[CH_W-1:0]].byte_mode;
                rdata[F_INCDST] <= chan_q[addr[CH_W-1:0]].inc_dst;
                rdata[F_CONT] <= chan_q[addr[CH_W-1:0]].cont;
            end else if (addr >= CH_SRC_BASE && addr < CH_DST_BASE) begin
                rdata <= chan_q[addr[CH_W-1:0]].src_ptr;
            end else if (addr >= CH_DST_BASE && addr < EDGE_CFG_ADDR) begin
                rdata <= chan_q[addr[CH_W-1:0]].dst_ptr;
            end else if (addr == EDGE_CFG_ADDR) begin
                rdata <= edge_cfg_q;
            end else if (addr == STATUS_ADDR) begin
                rdata[1:0] <= state_q;
                rdata[2 +: IDX_W] <= svc_idx_q;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/int_event_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module int_event_monitor
    import int_event_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [LVL_W-1:0] cpu_level,
    input wire logic hw_trap_active,
    input wire logic trap_req,
    input wire logic [7:0] trap_num,
    input wire logic cpu_ack,
    input wire logic irq_req,
    input wire irq_t irq_info,
    input wire logic xfer_go
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A vector outside the node table means a wrong winner index
    function automatic logic node_vec(input logic [9:0] v);
        node_vec = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (v == {TRAP_NUM[i], 2'h0}) node_vec = 1'b1;
        end
    endfunction
    a_xfer_single: assert property (xfer_go |=> !xfer_go)
        else $error("transfer pulse too long");
    a_xfer_nobranch: assert property ($rose(xfer_go) |-> !irq_req)
        else $error("transfer beside vector branch");
    a_irq_hold: assert property (irq_req && !cpu_ack |=> irq_req && $stable(irq_info))
        else $error("request dropped before ack");
    a_ack_drop: assert property (irq_req && cpu_ack |=> !irq_req)
        else $error("request kept after ack");
    a_trap_block: assert property ($rose(irq_req) || $rose(xfer_go) |-> !$past(hw_trap_active))
        else $error("service during hardware trap");
    a_level_above: assert property ($rose(irq_req) && !irq_info.trap |->
        irq_info.lvl > $past(cpu_level))
        else $error("level not above cpu level");
    a_node_vector: assert property ($rose(irq_req) && !irq_info.trap |->
        node_vec(irq_info.vector))
        else $error("vector not a node vector");
    // Trap is latched on one edge and raised on the next, once the sequencer is free
    a_trap_vector: assert property (trap_req && !irq_req && !xfer_go && !hw_trap_active
        ##1 !irq_req && !xfer_go && !hw_trap_active |=> irq_req && irq_info.trap
        && irq_info.lvl == $past(cpu_level)
        && irq_info.vector == {$past(trap_num, 2), 2'h0})
        else $error("trap vector wrong");
    // Main scenarios
    c_irq: cover property ($rose(irq_req) && !irq_info.trap);
    c_xfer: cover property (xfer_go);
    c_trap: cover property ($rose(irq_req) && irq_info.trap);
endmodule
bind int_event_unit int_event_monitor int_event_monitor_inst (.clk, .rst_b, .cpu_level,
    .hw_trap_active, .trap_req, .trap_num, .cpu_ack, .irq_req, .irq_info, .xfer_go);
`default_nettype wire

// ==== verification/cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic irq_req,
    input wire logic [3:0] ack_dly,
    output logic cpu_ack
);
    logic [3:0] wait_q;
    // One ack per request after a variable delay, so holding is exercised
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 4'h0;
            cpu_ack <= 1'b0;
        end else begin
            cpu_ack <= 1'b0;
            if (!irq_req || cpu_ack) wait_q <= 4'h0;
            else if (wait_q >= ack_dly) cpu_ack <= 1'b1;
            else wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/int_event_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module int_event_unit_tb
    import int_event_pkg::*;
;
    logic clk, rst_b, wr, rd, hw_trap_active, trap_req, cpu_ack, irq_req, xfer_go;
    logic [7:0] addr, ext_pin, trap_num;
    logic [15:0] wdata, rdata, sp, dp;
    logic [26:0] src_evt;
    logic [3:0] cpu_level, ack_dly;
    irq_t irq_info;
    xfer_t xfer_info;
    int seed, failures, check_count, n, a, b, la, lb, w;
    int_event_unit int_event_unit_inst (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
        .ext_pin, .src_evt, .cpu_level, .hw_trap_active, .trap_req, .trap_num, .cpu_ack,
        .irq_req, .irq_info, .xfer_go, .xfer_info);
    cpu_model cpu_model_inst (.clk, .rst_b, .irq_req, .ack_dly, .cpu_ack);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [9:0] vec_of(input int i);
        return {TRAP_NUM[i], 2'h0};
    endfunction
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        check_count++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [15:0] e);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic pulse(input logic [26:0] m);
        @(posedge clk);
        src_evt <= m;
        @(posedge clk);
        src_evt <= '0;
    endtask
    // Bounded wait; running out ends the run as a failure
    // Bound is the response budget, so a slow service fails here
    task automatic poll(input logic on_xfer, input logic val);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1;
            if ((on_xfer ? xfer_go : irq_req) === val) return;
        end
        failures++;
        $display("[ERR] %0t wait ran out", $time);
        wrap_up();
    endtask
    task automatic exp_irq(input logic [9:0] v, input logic [3:0] l, input logic t);
        poll(1'b0, 1'b1);
        chk(16'(irq_info.vector), 16'(v));
        chk(16'(irq_info.lvl), 16'(l));
        chk(16'(irq_info.trap), 16'(t));
        poll(1'b0, 1'b0);
    endtask
    task automatic no_irq;
        repeat (14) begin
            @(posedge clk);
            #1;
            chk(16'(irq_req), 16'h0000);
        end
    endtask
    initial begin
        seed = 23547;
        failures = 0;
        check_count = 0;
        {rst_b, wr, rd, hw_trap_active, trap_req} = '0;
        {addr, ext_pin, trap_num, wdata, src_evt, cpu_level} = '0;
        ack_dly = 4'h1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // Reset state, unmapped address reads zero
        rd_chk(SRC_BASE, 16'h0000);
        rd_chk(CH_CTRL_BASE, 16'h0000);
        rd_chk(8'h3F, 16'h0000);
        // Software-set flags at every level; level 0 never beats cpu level 0
        for (int l = 0; l < 16; l++) begin
            n = $unsigned($random(seed)) % NUM_SRC;
            ack_dly <= 4'($random(seed) & 3);
            wr_reg(SRC_BASE + 8'(n), 16'h0300 | 16'(l));
            if (l == 0) no_irq();
            else exp_irq(vec_of(n), 4'(l), 1'b0);
            rd_chk(SRC_BASE + 8'(n), (l == 0 ? 16'h0300 : 16'h0100) | 16'(l));
            wr_reg(SRC_BASE + 8'(n), 16'h0000);
        end
        // Two events at once; first case is a tie
        for (int k = 0; k < 5; k++) begin
            a = 8 + $unsigned($random(seed)) % 19;
            b = 8 + (a - 7 + $unsigned($random(seed)) % 18) % 19;
            la = 1 + $unsigned($random(seed)) % 15;
            lb = (k == 0) ? la : 1 + $unsigned($random(seed)) % 15;
            wr_reg(SRC_BASE + 8'(a), 16'h0100 | 16'(la));
            wr_reg(SRC_BASE + 8'(b), 16'h0100 | 16'(lb));
            pulse((27'(1) << a) | (27'(1) << b));
            w = (la > lb || (la == lb && a < b)) ? a : b;
            exp_irq(vec_of(w), 4'(w == a ? la : lb), 1'b0);
            w = a + b - w;
            exp_irq(vec_of(w), 4'(w == a ? la : lb), 1'b0);
        end
        // Equal level is refused, one below is served
        cpu_level <= 4'h7;
        wr_reg(SRC_BASE + 8'd10, 16'h0307);
        no_irq();
        cpu_level <= 4'h6;
        exp_irq(vec_of(10), 4'h7, 1'b0);
        cpu_level <= 4'h0;
        hw_trap_active <= 1'b1;
        wr_reg(SRC_BASE + 8'd15, 16'h0303);
        no_irq();
        hw_trap_active <= 1'b0;
        exp_irq(vec_of(15), 4'h3, 1'b0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            trap_num <= 8'($random(seed));
            cpu_level <= 4'($random(seed));
            trap_req <= 1'b1;
            @(posedge clk);
            trap_req <= 1'b0;
            exp_irq({trap_num, 2'h0}, cpu_level, 1'b1);
        end
        cpu_level <= 4'h0;
        // Channel c: bit 0 byte, bit 1 step destination, bit 2 continuous
        for (int c = 0; c < 8; c++) begin
            n = 8 + c;
            sp = 16'($random(seed));
            dp = 16'($random(seed));
            wr_reg(CH_SRC_BASE + 8'(c), sp);
            wr_reg(CH_DST_BASE + 8'(c), dp);
            wr_reg(CH_CTRL_BASE + 8'(c), (16'(c) << F_BYTE) | 16'h0002);
            wr_reg(SRC_BASE + 8'(n), 16'h0185 | (16'(c) << F_CHAN));
            for (int k = 0; k < 3; k++) begin
                pulse(27'(1) << n);
                if (k < 2 || c[2]) begin
                    poll(1'b1, 1'b1);
                    chk(xfer_info.src_addr, sp);
                    chk(xfer_info.dst_addr, dp);
                    chk(16'(xfer_info.byte_mode), 16'(c[0]));
                    chk(16'(irq_req), 16'h0000);
                    if (c[1]) dp += c[0] ? PTR_STEP_BYTE : PTR_STEP_WORD;
                    else sp += c[0] ? PTR_STEP_BYTE : PTR_STEP_WORD;
                end else begin
                    exp_irq(vec_of(n), 4'h5, 1'b0);
                end
            end
            rd_chk(CH_SRC_BASE + 8'(c), sp);
            rd_chk(CH_DST_BASE + 8'(c), dp);
            rd_chk(CH_CTRL_BASE + 8'(c), (16'(c) << F_BYTE) | 16'(c[2] * 2));
            rd_chk(SRC_BASE + 8'(n), 16'h0185 | (16'(c) << F_CHAN));
        end
        // Last service was node 15 by transfer; sequencer back to idle
        rd_chk(STATUS_ADDR, 16'(8 + 7) << 2);
        // Mid-run reset clears every register
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(SRC_BASE + 8'h0F, 16'h0000);
        rd_chk(CH_CTRL_BASE + 8'h07, 16'h0000);
        rd_chk(CH_SRC_BASE + 8'h07, 16'h0000);
        rd_chk(STATUS_ADDR, 16'h0000);
        // Edge code e on pin 2e: off, rise, fall, both
        for (int e = 0; e < 4; e++) begin
            wr_reg(EDGE_CFG_ADDR, 16'(e) << (4 * e));
            rd_chk(EDGE_CFG_ADDR, 16'(e) << (4 * e));
            wr_reg(SRC_BASE + 8'(2 * e), 16'h0104);
            ext_pin[2 * e] <= 1'b1;
            if (e[0]) exp_irq(vec_of(2 * e), 4'h4, 1'b0);
            else no_irq();
            ext_pin[2 * e] <= 1'b0;
            if (e[1]) exp_irq(vec_of(2 * e), 4'h4, 1'b0);
            else no_irq();
        end
        wrap_up();
    end
endmodule
`default_nettype wire
